// ==== include/bsgc_regs.svh ====
`ifndef BSGC_REGS_SVH
`define BSGC_REGS_SVH
// ****************************************
// configuration offsets (byte, dword aligned)
// ****************************************
`define BSGC_OFF_PMCAP 8'h50
`define BSGC_OFF_PMCSR 8'h54
`define BSGC_OFF_IDS 8'h84
`define BSGC_OFF_ALIAS 8'hd0
`define BSGC_OFF_GC 8'hd4
// ****************************************
// general control and identification fields and reset values
// ****************************************
`define BSGC_GC_RST 32'h8600025f
`define BSGC_GC_RETRY 31:30
`define BSGC_GC_PMDEF 29:28
`define BSGC_GC_LOWSW 27
`define BSGC_GC_PMREV 26
`define BSGC_GC_LO 25:0
`define BSGC_IDS_RST 32'h00000000
`define BSGC_IDS_HI 31:16
`define BSGC_IDS_LO 15:0
// ****************************************
// power-management reporting
// ****************************************
`define BSGC_PMCAP_REV 18:16
`define BSGC_PMCSR_NSR 3
`define BSGC_PM_REV_OLD 3'h2
`define BSGC_PM_REV_NEW 3'h3
// ****************************************
// retry timeouts in microseconds, clock in MHz, timer width
// ****************************************
`define BSGC_CLK_MHZ 10
`define BSGC_T25US_US 25
`define BSGC_T1MS_US 1000
`define BSGC_T25MS_US 25000
`define BSGC_T50MS_US 50000
`define BSGC_TMR_W 20
`endif

// ==== include/bsgc_pkg.sv ====
`include "bsgc_regs.svh"
package bsgc_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } bsgc_cfg_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } bsgc_cfg_rsp_s;

  typedef enum logic [1:0] {
    BSGC_IDLE = 2'b00,
    BSGC_COUNT = 2'b01,
    BSGC_EXPIRED = 2'b11
  } bsgc_tmr_e;

  typedef struct packed {
    bsgc_tmr_e st;
    logic [`BSGC_TMR_W-1:0] cnt;
    logic [`BSGC_TMR_W-1:0] limit;
    logic expired;
  } bsgc_tmr_s;

  typedef struct packed {
    logic [31:0] ids;
    logic [1:0] retrySel;
    logic [1:0] pmDef;
    logic lowSwing;
    logic pmRevSel;
    bsgc_cfg_rsp_s rsp;
    logic crsPermit;
    logic [1:0] linkPmDefault;
    logic txHalfSwing;
    logic txNoDeemph;
    logic [2:0] pmRevision;
    logic noSoftReset;
  } bsgc_gc_s;
endpackage

// ==== rtl/bsgc_retry_timer.sv ====
`timescale 1ns/100ps
`include "bsgc_regs.svh"
module bsgc_retry_timer #(
  parameter int CYC_25US = 250,
  parameter int CYC_1MS = 10000,
  parameter int CYC_25MS = 250000,
  parameter int CYC_50MS = 500000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] sel,
  output logic expired
);
  bsgc_pkg::bsgc_tmr_s st;
  bsgc_pkg::bsgc_tmr_s next_st;

  function automatic logic [`BSGC_TMR_W-1:0] limitOf(input logic [1:0] s);
    case (s)
      2'b00: limitOf = `BSGC_TMR_W'(CYC_25US);
      2'b01: limitOf = `BSGC_TMR_W'(CYC_1MS);
      2'b10: limitOf = `BSGC_TMR_W'(CYC_25MS);
      default: limitOf = `BSGC_TMR_W'(CYC_50MS);
    endcase
  endfunction

  always_comb begin
    next_st = st;
    case (st.st)
      bsgc_pkg::BSGC_IDLE: begin
        if (start) begin
          next_st.st = bsgc_pkg::BSGC_COUNT;
          next_st.cnt = '0;
          next_st.limit = limitOf(sel);
        end
      end
      bsgc_pkg::BSGC_COUNT: begin
        if (stop) begin
          next_st.st = bsgc_pkg::BSGC_IDLE;
        end else if (st.cnt == st.limit - `BSGC_TMR_W'(1)) begin
          next_st.st = bsgc_pkg::BSGC_EXPIRED;
          next_st.expired = 1'b1;
        end else begin
          next_st.cnt = st.cnt + `BSGC_TMR_W'(1);
        end
      end
      bsgc_pkg::BSGC_EXPIRED: begin
        if (stop) begin
          next_st.st = bsgc_pkg::BSGC_IDLE;
          next_st.expired = 1'b0;
        end
      end
      default: begin
        next_st.st = bsgc_pkg::BSGC_IDLE;
        next_st.expired = 1'b0;
      end
    endcase
    if (!rst_n) begin
      next_st = '{st: bsgc_pkg::BSGC_IDLE, cnt: '0, limit: '0, expired: 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign expired = st.expired;

  a_retry_limit: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(st.expired) |-> $past(st.cnt) == st.limit - `BSGC_TMR_W'(1))
    else $error("timeout expired at wrong count");
endmodule

// ==== rtl/bsgc_general_control.sv ====
`timescale 1ns/100ps
`include "bsgc_regs.svh"
module bsgc_general_control #(
  parameter int RETRY_1MS_CYC = `BSGC_T1MS_US * `BSGC_CLK_MHZ,
  parameter int RETRY_25MS_CYC = `BSGC_T25MS_US * `BSGC_CLK_MHZ,
  parameter int RETRY_50MS_CYC = `BSGC_T50MS_US * `BSGC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic warmReset,
  input bsgc_pkg::bsgc_cfg_req_s cfgReq,
  output bsgc_pkg::bsgc_cfg_rsp_s cfgRsp,
  input wire logic cfgFwdStart,
  input wire logic cfgFwdRetry,
  input wire logic cfgFwdEnd,
  output logic crsPermit,
  output logic [1:0] linkPmDefault,
  output logic txHalfSwing,
  output logic txNoDeemph,
  output logic [2:0] pmRevision,
  output logic noSoftReset
);
  localparam int RETRY_25US_CYC = `BSGC_T25US_US * `BSGC_CLK_MHZ;
  localparam logic [31:0] GC_RST = `BSGC_GC_RST;

  bsgc_pkg::bsgc_gc_s st;
  bsgc_pkg::bsgc_gc_s next_st;
  logic tmrExpired;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input bsgc_pkg::bsgc_cfg_req_s r, input logic [7:0] off);
    hit = r.valid && (r.addr[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // ****************************************
  // retry timing on the secondary bus
  // ****************************************
  // the timer latches the selector at start, so a rewrite cannot stretch a retry in flight
  bsgc_retry_timer #(
    .CYC_25US(RETRY_25US_CYC),
    .CYC_1MS(RETRY_1MS_CYC),
    .CYC_25MS(RETRY_25MS_CYC),
    .CYC_50MS(RETRY_50MS_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(cfgFwdStart),
    .stop(cfgFwdEnd),
    .sel(st.retrySel),
    .expired(tmrExpired)
  );

  // ****************************************
  // register state
  // ****************************************
  always_comb begin
    logic [31:0] gcNow;
    logic [31:0] gcNew;
    // bits 25:0 read back the fixed pattern; writes to them pass the merge, but only bits 31:26 are taken from it
    gcNow = {st.retrySel, st.pmDef, st.lowSwing, st.pmRevSel, GC_RST[`BSGC_GC_LO]};
    gcNew = merge(gcNow, cfgReq.wdata, cfgReq.byteEn);
    next_st = st;
    next_st.rsp.valid = 1'b0;
    next_st.rsp.rdata = '0;
    if (cfgReq.write) begin
      // the 84h view is read-only, so the single copy keeps both views equal
      if (hit(cfgReq, `BSGC_OFF_ALIAS)) begin
        next_st.ids = merge(st.ids, cfgReq.wdata, cfgReq.byteEn);
      end
      if (hit(cfgReq, `BSGC_OFF_GC)) begin
        next_st.retrySel = gcNew[`BSGC_GC_RETRY];
        next_st.pmDef = gcNew[`BSGC_GC_PMDEF];
        next_st.lowSwing = gcNew[`BSGC_GC_LOWSW];
        next_st.pmRevSel = gcNew[`BSGC_GC_PMREV];
      end
    end else if (cfgReq.valid) begin
      next_st.rsp.valid = 1'b1;
      if (hit(cfgReq, `BSGC_OFF_ALIAS) || hit(cfgReq, `BSGC_OFF_IDS)) begin
        next_st.rsp.rdata = st.ids;
      end else if (hit(cfgReq, `BSGC_OFF_GC)) begin
        next_st.rsp.rdata = gcNow;
      end else if (hit(cfgReq, `BSGC_OFF_PMCAP)) begin
        next_st.rsp.rdata[`BSGC_PMCAP_REV] = st.pmRevision;
      end else if (hit(cfgReq, `BSGC_OFF_PMCSR)) begin
        next_st.rsp.rdata[`BSGC_PMCSR_NSR] = st.noSoftReset;
      end
    end
    // warm reset clears only the field that is not fundamental-only
    if (warmReset) begin
      next_st.pmDef = GC_RST[`BSGC_GC_PMDEF];
    end
    // registered, so retry status lags the expiry by one cycle and never precedes it
    next_st.crsPermit = tmrExpired && cfgFwdRetry && !cfgFwdEnd;
    next_st.linkPmDefault = next_st.pmDef;
    next_st.txHalfSwing = next_st.lowSwing;
    next_st.txNoDeemph = next_st.lowSwing;
    next_st.pmRevision = next_st.pmRevSel ? `BSGC_PM_REV_NEW : `BSGC_PM_REV_OLD;
    next_st.noSoftReset = next_st.pmRevSel;
    if (!rst_n) begin
      next_st.ids = `BSGC_IDS_RST;
      next_st.retrySel = GC_RST[`BSGC_GC_RETRY];
      next_st.pmDef = GC_RST[`BSGC_GC_PMDEF];
      next_st.lowSwing = GC_RST[`BSGC_GC_LOWSW];
      next_st.pmRevSel = GC_RST[`BSGC_GC_PMREV];
      next_st.rsp = '0;
      next_st.crsPermit = 1'b0;
      next_st.linkPmDefault = GC_RST[`BSGC_GC_PMDEF];
      next_st.txHalfSwing = GC_RST[`BSGC_GC_LOWSW];
      next_st.txNoDeemph = GC_RST[`BSGC_GC_LOWSW];
      next_st.pmRevision = GC_RST[`BSGC_GC_PMREV] ? `BSGC_PM_REV_NEW : `BSGC_PM_REV_OLD;
      next_st.noSoftReset = GC_RST[`BSGC_GC_PMREV];
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign cfgRsp = st.rsp;
  assign crsPermit = st.crsPermit;
  assign linkPmDefault = st.linkPmDefault;
  assign txHalfSwing = st.txHalfSwing;
  assign txNoDeemph = st.txNoDeemph;
  assign pmRevision = st.pmRevision;
  assign noSoftReset = st.noSoftReset;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_alias_wr(logic [3:0] be);
    cfgReq.valid && cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_ALIAS >> 2 && cfgReq.byteEn == be;
  endsequence

  sequence s_gc_wr;
    cfgReq.valid && cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_GC >> 2 && cfgReq.byteEn[3] && !warmReset;
  endsequence

  a_alias_hi_wr: assert property (s_alias_wr(4'hc) |=>
    st.ids[`BSGC_IDS_HI] == $past(cfgReq.wdata[`BSGC_IDS_HI]) && $stable(st.ids[`BSGC_IDS_LO]))
    else $error("board id not updated");
  a_alias_lo_wr: assert property (s_alias_wr(4'h3) |=>
    st.ids[`BSGC_IDS_LO] == $past(cfgReq.wdata[`BSGC_IDS_LO]) && $stable(st.ids[`BSGC_IDS_HI]))
    else $error("board maker id not updated");
  a_warm_keeps: assert property (warmReset && !cfgReq.valid |=>
    $stable(st.retrySel) && $stable(st.lowSwing) && $stable(st.pmRevSel) && $stable(st.ids)
    && linkPmDefault == 2'b00)
    else $error("warm reset disturbed fundamental-only fields");
  a_crs_gate: assert property (crsPermit |-> $past(tmrExpired) && $past(cfgFwdRetry))
    else $error("retry status allowed before timeout");
  a_pmdef_out: assert property (s_gc_wr |=> linkPmDefault == $past(cfgReq.wdata[`BSGC_GC_PMDEF]))
    else $error("link pm default not following selector");
  a_low_swing: assert property (s_gc_wr |=>
    txHalfSwing == $past(cfgReq.wdata[`BSGC_GC_LOWSW]) && txNoDeemph == txHalfSwing)
    else $error("low swing outputs wrong");
  a_pm_rev: assert property (s_gc_wr |=>
    pmRevision == ($past(cfgReq.wdata[`BSGC_GC_PMREV]) ? 3'h3 : 3'h2)
    && noSoftReset == $past(cfgReq.wdata[`BSGC_GC_PMREV]))
    else $error("pm revision report wrong");
  a_pm_read: assert property (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_PMCAP >> 2
    |=> cfgRsp.valid && cfgRsp.rdata[`BSGC_PMCAP_REV] == pmRevision)
    else $error("pm capabilities read wrong");
  a_alias_read: assert property (cfgReq.valid && !cfgReq.write &&
    (cfgReq.addr[7:2] == `BSGC_OFF_IDS >> 2 || cfgReq.addr[7:2] == `BSGC_OFF_ALIAS >> 2)
    |=> cfgRsp.valid && cfgRsp.rdata == $past(st.ids))
    else $error("identification views disagree");

  // the 84h view has no storage of its own, so a write there must change nothing
  a_ids_ro: assert property (cfgReq.valid && cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_IDS >> 2
    |=> $stable(st.ids))
    else $error("read-only id view was written");
  a_pmcsr_read: assert property (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_PMCSR >> 2
    |=> cfgRsp.valid && cfgRsp.rdata[`BSGC_PMCSR_NSR] == noSoftReset)
    else $error("pm control/status read wrong");
  // the fixed low bits must never pick up stale write data
  a_gc_read: assert property (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == `BSGC_OFF_GC >> 2
    |=> cfgRsp.valid && cfgRsp.rdata[`BSGC_GC_RETRY] == $past(st.retrySel)
    && cfgRsp.rdata[`BSGC_GC_LO] == GC_RST[`BSGC_GC_LO])
    else $error("general control read wrong");
  // a response with no read behind it would look like a stray completion
  a_rsp_pulse: assert property (cfgRsp.valid |-> $past(cfgReq.valid) && !$past(cfgReq.write))
    else $error("response without a read");

  sequence s_crs_due;
    tmrExpired && cfgFwdRetry && !cfgFwdEnd;
  endsequence

  a_crs_rise: assert property (s_crs_due |=> crsPermit)
    else $error("retry status not allowed after timeout");
  a_crs_end: assert property (cfgFwdEnd |=> !crsPermit)
    else $error("retry status still allowed after the request ended");
  // first cycle out of a fundamental reset shows every power-up default except txNoDeemph and cfgRsp
  a_rst_dflt: assert property ($rose(rst_n) |->
    linkPmDefault == 2'b00 && !txHalfSwing && pmRevision == `BSGC_PM_REV_NEW && noSoftReset && !crsPermit
    && st.ids == `BSGC_IDS_RST && st.retrySel == GC_RST[`BSGC_GC_RETRY] && st.pmRevSel)
    else $error("power-up defaults wrong");
endmodule

// ==== rtl/unused_placeholder_none.sv ====
`timescale 1ns/100ps

// ==== verif/bsgc_host_model.sv ====
`timescale 1ns/100ps
module bsgc_host_model (
  input wire logic clk,
  output bsgc_pkg::bsgc_cfg_req_s cfgReq,
  input bsgc_pkg::bsgc_cfg_rsp_s cfgRsp
);
  // ****************************************
  // one-cycle configuration requests
  // ****************************************
  initial begin
    cfgReq = '0;
  end

  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] r, output logic rv);
    @(posedge clk);
    #10;
    cfgReq.valid = 1'b1;
    cfgReq.write = wr;
    cfgReq.addr = a;
    cfgReq.byteEn = be;
    cfgReq.wdata = d;
    @(posedge clk);
    #10;
    rv = cfgRsp.valid;
    r = cfgRsp.rdata;
    // released fields inverted so a stale value cannot look valid
    cfgReq.valid = 1'b0;
    cfgReq.write = ~wr;
    cfgReq.addr = ~a;
    cfgReq.byteEn = ~be;
    cfgReq.wdata = ~d;
  endtask
endmodule

// ==== verif/bsgc_general_control_tb.sv ====
`timescale 1ns/100ps
module bsgc_general_control_tb;
  logic clk, rst_n, warmReset, cfgFwdStart, cfgFwdRetry, cfgFwdEnd, rv;
  logic crsPermit, txHalfSwing, txNoDeemph, noSoftReset;
  logic [1:0] linkPmDefault;
  logic [2:0] pmRevision;
  logic [31:0] rd;
  bsgc_pkg::bsgc_cfg_req_s cfgReq;
  bsgc_pkg::bsgc_cfg_rsp_s cfgRsp;
  int errorCnt, nChecks, cyc, k;
  // short retry counts keep the run brief; 25us stays at 250
  int tmo[4] = '{250, 20, 40, 60};

  bsgc_general_control #(.RETRY_1MS_CYC(20), .RETRY_25MS_CYC(40), .RETRY_50MS_CYC(60)) bsgc_general_control_i (
    .clk(clk), .rst_n(rst_n), .warmReset(warmReset), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .cfgFwdStart(cfgFwdStart), .cfgFwdRetry(cfgFwdRetry), .cfgFwdEnd(cfgFwdEnd), .crsPermit(crsPermit),
    .linkPmDefault(linkPmDefault), .txHalfSwing(txHalfSwing), .txNoDeemph(txNoDeemph),
    .pmRevision(pmRevision), .noSoftReset(noSoftReset));
  bsgc_host_model bsgc_host_model_i (.clk(clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errorCnt++;
      giveVerdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    nChecks++;
    if (s !== e) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bsgc_host_model_i.access(1'b0, a, 4'hf, 32'h0, rd, rv);
    chk({nm, " answer"}, 32'h1, 32'(rv));
    chk(nm, e, rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    bsgc_host_model_i.access(1'b1, a, be, d, rd, rv);
  endtask

  task automatic step();
    @(posedge clk);
    #10;
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    warmReset = 1'b0;
    cfgFwdStart = 1'b0;
    cfgFwdRetry = 1'b0;
    cfgFwdEnd = 1'b0;
    repeat (12) @(posedge clk);
    #10;
    rst_n = 1'b1;
    rdc("gc", 8'hd4, 32'h8600025f);
    rdc("pmcap", 8'h50, 32'h00030000);
    rdc("pmcsr", 8'h54, 32'h00000008);
    rdc("ids", 8'h84, 32'h0);
    chk("txHalfSwing", 32'h0, 32'(txHalfSwing));
    $display("test reset values done");

    wr(8'hd0, 4'hf, 32'h12345678);
    rdc("alias", 8'hd0, 32'h12345678);
    rdc("ids", 8'h84, 32'h12345678);
    wr(8'hd0, 4'hc, 32'habcd0000);
    rdc("id hi", 8'h84, 32'habcd5678);
    rdc("id 86h", 8'h86, 32'habcd5678);
    wr(8'hd0, 4'h3, 32'h0000ef01);
    rdc("id lo", 8'h84, 32'habcdef01);
    wr(8'h84, 4'hf, 32'h0);
    rdc("alias ro", 8'hd0, 32'habcdef01);
    $display("test alias done");

    for (int n = 0; n < 4; n++) begin
      wr(8'hd4, 4'h8, {n[1:0], n[1:0], n[0], n[1], 26'h0});
      chk("linkPmDefault", 32'(n), 32'(linkPmDefault));
      chk("txHalfSwing", 32'(n[0]), 32'(txHalfSwing));
      chk("txNoDeemph", 32'(n[0]), 32'(txNoDeemph));
      chk("pmRevision", n[1] ? 32'h3 : 32'h2, 32'(pmRevision));
      chk("noSoftReset", 32'(n[1]), 32'(noSoftReset));
      rdc("pmcap", 8'h50, {13'h0, n[1] ? 3'h3 : 3'h2, 16'h0});
      rdc("pmcsr", 8'h54, {28'h0, n[1], 3'h0});
      rdc("gc", 8'hd4, {n[1:0], n[1:0], n[0], n[1], 26'h200025f});
    end
    $display("test control fields done");

    warmReset = 1'b1;
    step();
    warmReset = 1'b0;
    chk("linkPmDefault warm", 32'h0, 32'(linkPmDefault));
    rdc("gc warm", 8'hd4, {2'b11, 2'b00, 2'b11, 26'h200025f});
    rdc("ids warm", 8'h84, 32'habcdef01);
    $display("test warm reset done");

    for (int n = 0; n < 4; n++) begin
      wr(8'hd4, 4'h8, {n[1:0], 6'h01, 24'h0});
      cfgFwdRetry = 1'b1;
      cfgFwdStart = 1'b1;
      step();
      cfgFwdStart = 1'b0;
      k = 0;
      while (crsPermit !== 1'b1 && k < 1000) begin
        step();
        k++;
      end
      // expiry lands after the full count, the registered permit one cycle later
      chk("retry wait", 32'(tmo[n] + 1), 32'(k));
      cfgFwdEnd = 1'b1;
      step();
      cfgFwdEnd = 1'b0;
      cfgFwdRetry = 1'b0;
      chk("crsPermit end", 32'h0, 32'(crsPermit));
    end
    $display("test retry timeout done");

    rst_n = 1'b0;
    step();
    rst_n = 1'b1;
    rdc("gc full", 8'hd4, 32'h8600025f);
    rdc("ids full", 8'hd0, 32'h0);
    $display("test full reset done");
    giveVerdict();
  end
endmodule
